// [verilog/sdpd_pkg.sv]
// sdpd_pkg: constants and types of the sdram power-down timing controller
// assumes hclk at 40 MHz also clocks the dram, so one dram clock is one hclk cycle
package sdpd_pkg;

    localparam int CLK_PERIOD_PS = 25000;
    localparam int CLK_PERIOD_NS = 25;

    localparam int XP_MIN_CK    = 4;
    localparam int XP_MIN_PS    = 6000;
    localparam int XP_CYC       = ((XP_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS > XP_MIN_CK)
                                ? (XP_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS : XP_MIN_CK;
    localparam int CKE_MIN_CK   = 3;
    localparam int CKE_MIN_PS   = 5000;
    localparam int CKE_CYC      = ((CKE_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS > CKE_MIN_CK)
                                ? (CKE_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS : CKE_MIN_CK;
    localparam int CAL_MIN_CK   = 3;
    localparam int CAL_MIN_PS   = 3748;
    localparam int CAL_CYC      = ((CAL_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS > CAL_MIN_CK)
                                ? (CAL_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS : CAL_MIN_CK;
    localparam int REFI_MAX_PS  = 7800000;
    localparam int REFI_CYC     = REFI_MAX_PS / CLK_PERIOD_PS;
    localparam int RES_MAX_REFI = 9;
    localparam int RES_MAX_CYC  = RES_MAX_REFI * REFI_CYC;
    localparam int CPDED_CYC    = 4;

    localparam int ACT_GAP      = 1;
    localparam int PRE_GAP_LO   = 1;
    localparam int PRE_GAP_HI   = 2;
    localparam int RD_POST      = 4;
    localparam int RD_PAD       = 1;
    localparam int WR_POST_BL8  = 4;
    localparam int WR_POST_BC4  = 2;
    localparam int WRA_PAD      = 1;

    localparam int GAP_W        = 10;
    localparam int RES_W        = 12;
    localparam int LAT_W        = 6;
    localparam int PL_W         = 4;

    localparam logic [7:0] CTRL_OFF   = 8'h00;
    localparam logic [7:0] TIMING_OFF = 8'h04;
    localparam logic [7:0] CMD_OFF    = 8'h08;
    localparam logic [7:0] STATUS_OFF = 8'h0C;

    localparam int CTRL_RL_LSB  = 0;
    localparam int CTRL_WL_LSB  = 8;
    localparam int CTRL_PL_LSB  = 16;
    localparam int CTRL_PAR_BIT = 24;
    localparam int CTRL_DLL_BIT = 25;
    localparam int CTRL_SPD_BIT = 26;
    localparam int CTRL_BC4_BIT = 27;
    localparam int TIM_WR_LSB   = 0;
    localparam int TIM_MOD_LSB  = 8;
    localparam int TIM_RFC_LSB  = 16;
    localparam int TIM_CAL_LSB  = 28;
    localparam int CMD_CODE_LSB = 0;
    localparam int CMD_ENTR_BIT = 8;
    localparam int CMD_EXIT_BIT = 9;
    localparam int ST_RDY_BIT   = 0;
    localparam int ST_SLP_BIT   = 1;
    localparam int ST_REF_BIT   = 3;
    localparam int ST_FSM_LSB   = 4;

    localparam logic [31:0] CTRL_RESET   = 32'h0000_090B;
    localparam logic [31:0] TIMING_RESET = 32'h300E_180F;

    typedef enum logic [3:0] {
        CMD_DESEL = 4'h0, CMD_ACT = 4'h1, CMD_PRE = 4'h2, CMD_PREA = 4'h3,
        CMD_REF   = 4'h4, CMD_MRS = 4'h5, CMD_RD  = 4'h6, CMD_RDA  = 4'h7,
        CMD_WR    = 4'h8, CMD_WRA = 4'h9
    } sdpd_cmd_type;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_SLEEP = 2'b01,
        ST_WAKE  = 2'b11
    } sdpd_state_type;

endpackage

// [verilog/sdpd_gap_if.sv]
// sdpd_gap_if: load and expiry of one minimum-gap timer
// assumes the owner and the timer share hclk
`timescale 1ns/1ps
interface sdpd_gap_if #(parameter int W = 10);
    logic         load;
    logic [W-1:0] value;
    logic         zero;
    modport owner (output load, output value, input zero);
    modport timer (input load, input value, output zero);
endinterface

// [verilog/sdpd_gap_timer.sv]
// sdpd_gap_timer: down counter that keeps the longest pending gap
// assumes value is the gap in cycles minus one
`timescale 1ns/1ps
module sdpd_gap_timer (
    input wire logic  hclk,
    input wire logic  hresetn,
    sdpd_gap_if.timer gap
);
    localparam int W = $bits(gap.value);

    logic [W-1:0] count;
    logic [W-1:0] next_count;

    if (W < 2) begin : g_width_check
        $error("gap timer needs at least two bits");
    end

    always_comb begin
        next_count = (count != '0) ? count - 1'b1 : count;
        if (gap.load && gap.value > next_count) begin
            next_count = gap.value;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            count <= '0;
        end else begin
            count <= next_count;
        end
    end

    assign gap.zero = (count == '0);
endmodule

// [verilog/sdpd_residency.sv]
// sdpd_residency: saturating count of cycles spent in power-down
// assumes run is a registered level that drops when the sleep ends
`timescale 1ns/1ps
module sdpd_residency #(
    parameter int W    = 12,
    parameter int MAXV = 2900
) (
    input  wire logic         hclk,
    input  wire logic         hresetn,
    input  wire logic         run,
    output logic [W-1:0]      count
);
    if (MAXV >= (1 << W) - 1) begin : g_width_check
        $error("residency counter too narrow for the longest sleep");
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            count <= '0;
        end else if (!run) begin
            count <= '0;
        end else if (count != '1) begin
            count <= count + 1'b1;
        end
    end
endmodule

// [verilog/sdpd_ctrl.sv]
// sdpd_ctrl: ahb-lite controlled driver of sdram command and clock-enable pins
// assumes one ahb-lite master, dram clocked by hclk, pins registered here
`timescale 1ns/1ps
module sdpd_ctrl (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    output logic             dram_cke,
    output logic      [3:0]  dram_cmd
);
    localparam int GW = sdpd_pkg::GAP_W;
    localparam int RW = sdpd_pkg::RES_W;

    logic [31:0]                ctrl;
    logic [31:0]                timing;
    logic                       refused;
    logic                       dph_wr;
    logic [7:0]                 dph_addr;
    sdpd_pkg::sdpd_state_type   state;
    sdpd_pkg::sdpd_cmd_type     code;
    logic [sdpd_pkg::LAT_W-1:0] rl;
    logic [sdpd_pkg::LAT_W-1:0] wl;
    logic [sdpd_pkg::LAT_W-1:0] wl_eff;
    logic [sdpd_pkg::PL_W-1:0]  pl;
    logic [7:0]                 wr_ns;
    logic [7:0]                 mod_cyc;
    logic [9:0]                 rfc_cyc;
    logic [GW-1:0]              wr_cyc;
    logic [GW-1:0]              post;
    logic [GW-1:0]              rd_gap;
    logic [GW-1:0]              wr_gap;
    logic [GW-1:0]              wra_gap;
    logic [GW-1:0]              pre_gap;
    logic [GW-1:0]              mod_gap;
    logic [GW-1:0]              rfc_gap;
    logic [GW-1:0]              xp_gap;
    logic [GW-1:0]              cmd_gap;
    logic [RW-1:0]              res_count;
    logic [RW-1:0]              res_min;
    logic [RW-1:0]              res_max;
    logic                       wr_ctrl;
    logic                       wr_timing;
    logic                       wr_cmd;
    logic                       wr_status;
    logic                       cmd_ok;
    logic                       enter_ok;
    logic                       leave;
    logic                       refuse_now;
    logic                       par_en;
    logic                       dll_off;
    logic                       speed_hi;
    logic                       chop;
    logic [GW-1:0]              cmd_age;
    logic [GW-1:0]              cmd_need;
    logic [GW-1:0]              wake_age;
    logic [GW-1:0]              wake_need;

    sdpd_gap_if #(.W(GW)) pde_if ();
    sdpd_gap_if #(.W(GW)) blk_if ();
    sdpd_gap_if #(.W(GW)) hold_if ();
    sdpd_gap_if #(.W(GW)) xp_if ();

    sdpd_gap_timer u_pde (.hclk(hclk), .hresetn(hresetn), .gap(pde_if.timer));
    sdpd_gap_timer u_blk (.hclk(hclk), .hresetn(hresetn), .gap(blk_if.timer));
    sdpd_gap_timer u_hold (.hclk(hclk), .hresetn(hresetn), .gap(hold_if.timer));
    sdpd_gap_timer u_xp (.hclk(hclk), .hresetn(hresetn), .gap(xp_if.timer));

    sdpd_residency #(
        .W    (RW),
        .MAXV (sdpd_pkg::RES_MAX_CYC + (1 << sdpd_pkg::LAT_W))
    ) u_res (
        .hclk    (hclk),
        .hresetn (hresetn),
        .run     (state == sdpd_pkg::ST_SLEEP),
        .count   (res_count)
    );

    // ahb-lite slave, zero wait states
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dph_wr <= 1'b0;
            dph_addr <= 8'h00;
            hreadyout <= 1'b0;
            hresp <= 1'b0;
        end else begin
            dph_wr <= hsel && htrans[1] && hready && hwrite;
            dph_addr <= haddr[7:0];
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (hsel && htrans[1] && hready && !hwrite) begin
            case (haddr[7:0])
                sdpd_pkg::CTRL_OFF: hrdata <= ctrl;
                sdpd_pkg::TIMING_OFF: hrdata <= timing;
                sdpd_pkg::STATUS_OFF: begin
                    hrdata <= 32'h0000_0000;
                    hrdata[sdpd_pkg::ST_RDY_BIT] <= state == sdpd_pkg::ST_IDLE && blk_if.zero;
                    hrdata[sdpd_pkg::ST_SLP_BIT] <= !dram_cke;
                    hrdata[sdpd_pkg::ST_REF_BIT] <= refused;
                    hrdata[sdpd_pkg::ST_FSM_LSB +: 2] <= state;
                end
                default: hrdata <= 32'h0000_0000;
            endcase
        end
    end

    assign wr_ctrl   = dph_wr && dph_addr == sdpd_pkg::CTRL_OFF;
    assign wr_timing = dph_wr && dph_addr == sdpd_pkg::TIMING_OFF;
    assign wr_cmd    = dph_wr && dph_addr == sdpd_pkg::CMD_OFF;
    assign wr_status = dph_wr && dph_addr == sdpd_pkg::STATUS_OFF;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl <= sdpd_pkg::CTRL_RESET;
            timing <= sdpd_pkg::TIMING_RESET;
        end else begin
            if (wr_ctrl) begin
                ctrl <= hwdata;
            end
            if (wr_timing && hwdata[sdpd_pkg::TIM_CAL_LSB +: 4] >= 4'(sdpd_pkg::CAL_CYC)) begin
                timing <= hwdata;
            end
        end
    end

    // field decode
    assign rl       = ctrl[sdpd_pkg::CTRL_RL_LSB +: sdpd_pkg::LAT_W];
    assign wl       = ctrl[sdpd_pkg::CTRL_WL_LSB +: sdpd_pkg::LAT_W];
    assign pl       = ctrl[sdpd_pkg::CTRL_PL_LSB +: sdpd_pkg::PL_W];
    assign par_en   = ctrl[sdpd_pkg::CTRL_PAR_BIT];
    assign dll_off  = ctrl[sdpd_pkg::CTRL_DLL_BIT];
    assign speed_hi = ctrl[sdpd_pkg::CTRL_SPD_BIT];
    assign chop     = ctrl[sdpd_pkg::CTRL_BC4_BIT];
    assign wr_ns    = timing[sdpd_pkg::TIM_WR_LSB +: 8];
    assign mod_cyc  = timing[sdpd_pkg::TIM_MOD_LSB +: 8];
    assign rfc_cyc  = timing[sdpd_pkg::TIM_RFC_LSB +: 10];
    assign code     = sdpd_pkg::sdpd_cmd_type'(hwdata[sdpd_pkg::CMD_CODE_LSB +: 4]);
    assign wl_eff   = (wl == '0) ? sdpd_pkg::LAT_W'(1) : wl;

    // gap figures in clocks
    assign wr_cyc  = GW'((GW'(wr_ns) + GW'(sdpd_pkg::CLK_PERIOD_NS - 1))
                   / GW'(sdpd_pkg::CLK_PERIOD_NS));
    assign post    = chop ? GW'(sdpd_pkg::WR_POST_BC4) : GW'(sdpd_pkg::WR_POST_BL8);
    assign rd_gap  = GW'(rl) + GW'(sdpd_pkg::RD_POST + sdpd_pkg::RD_PAD);
    assign wr_gap  = GW'(wl) + post + wr_cyc;
    assign wra_gap = GW'(wl) + post + wr_cyc + GW'(sdpd_pkg::WRA_PAD);
    assign pre_gap = speed_hi ? GW'(sdpd_pkg::PRE_GAP_HI) : GW'(sdpd_pkg::PRE_GAP_LO);
    assign mod_gap = (mod_cyc == 8'h00) ? GW'(1) : GW'(mod_cyc);
    assign rfc_gap = ((rfc_cyc == 10'h000) ? GW'(1) : GW'(rfc_cyc))
                   + ((par_en && dll_off) ? GW'(pl) : GW'(0));
    assign xp_gap  = GW'(sdpd_pkg::XP_CYC) + (par_en ? GW'(pl) : GW'(0));
    assign res_min = RW'(sdpd_pkg::CKE_CYC) + RW'(wl_eff) - RW'(1);
    assign res_max = RW'(sdpd_pkg::RES_MAX_CYC) + RW'(wl_eff) - RW'(1);

    always_comb begin
        case (code)
            sdpd_pkg::CMD_ACT: cmd_gap = GW'(sdpd_pkg::ACT_GAP);
            sdpd_pkg::CMD_PRE, sdpd_pkg::CMD_PREA, sdpd_pkg::CMD_REF: cmd_gap = pre_gap;
            sdpd_pkg::CMD_MRS: cmd_gap = mod_gap;
            sdpd_pkg::CMD_RD, sdpd_pkg::CMD_RDA: cmd_gap = rd_gap;
            sdpd_pkg::CMD_WR: cmd_gap = wr_gap;
            sdpd_pkg::CMD_WRA: cmd_gap = wra_gap;
            default: cmd_gap = GW'(1);
        endcase
    end

    // request arbitration
    assign cmd_ok   = wr_cmd && code != sdpd_pkg::CMD_DESEL && state == sdpd_pkg::ST_IDLE
                    && blk_if.zero;
    assign enter_ok = wr_cmd && code == sdpd_pkg::CMD_DESEL && hwdata[sdpd_pkg::CMD_ENTR_BIT]
                    && state == sdpd_pkg::ST_IDLE && pde_if.zero && hold_if.zero
                    && blk_if.zero;
    assign leave    = state == sdpd_pkg::ST_SLEEP && hold_if.zero
                    && ((wr_cmd && hwdata[sdpd_pkg::CMD_EXIT_BIT] && res_count >= res_min)
                    || res_count >= res_max - RW'(1));
    assign refuse_now = wr_cmd && !cmd_ok && !enter_ok && !leave
                      && (code != sdpd_pkg::CMD_DESEL || hwdata[sdpd_pkg::CMD_ENTR_BIT]
                      || hwdata[sdpd_pkg::CMD_EXIT_BIT]);

    assign pde_if.load   = cmd_ok;
    assign pde_if.value  = cmd_gap - GW'(1);
    assign blk_if.load   = cmd_ok && code == sdpd_pkg::CMD_REF;
    assign blk_if.value  = rfc_gap - GW'(1);
    assign hold_if.load  = enter_ok || leave;
    assign hold_if.value = GW'(sdpd_pkg::CKE_CYC - 1);
    assign xp_if.load    = leave;
    assign xp_if.value   = xp_gap - GW'(1);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state <= sdpd_pkg::ST_IDLE;
        end else begin
            case (state)
                sdpd_pkg::ST_IDLE: if (enter_ok) state <= sdpd_pkg::ST_SLEEP;
                sdpd_pkg::ST_SLEEP: if (leave) state <= sdpd_pkg::ST_WAKE;
                sdpd_pkg::ST_WAKE: if (xp_if.zero) state <= sdpd_pkg::ST_IDLE;
                default: state <= sdpd_pkg::ST_IDLE;
            endcase
        end
    end

    // dram pins
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dram_cke <= 1'b1;
        end else if (enter_ok) begin
            dram_cke <= 1'b0;
        end else if (leave) begin
            dram_cke <= 1'b1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dram_cmd <= sdpd_pkg::CMD_DESEL;
        end else begin
            dram_cmd <= cmd_ok ? code : sdpd_pkg::CMD_DESEL;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            refused <= 1'b0;
        end else if (refuse_now) begin
            refused <= 1'b1;
        end else if (wr_status && hwdata[sdpd_pkg::ST_REF_BIT]) begin
            refused <= 1'b0;
        end
    end

    // cycles since the last command, and the gap that it asked for
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cmd_age <= '1;
            cmd_need <= '0;
        end else if (cmd_ok) begin
            cmd_age <= '0;
            cmd_need <= cmd_gap;
        end else if (cmd_age != '1) begin
            cmd_age <= cmd_age + 1'b1;
        end
    end

    // cycles since the last exit, and the exit delay in force then
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wake_age <= '1;
            wake_need <= '0;
        end else if (leave) begin
            wake_age <= '0;
            wake_need <= xp_gap;
        end else if (wake_age != '1) begin
            wake_age <= wake_age + 1'b1;
        end
    end

    default clocking dcb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    a_exit_wait: assert property ($rose(dram_cke) |-> (dram_cmd == sdpd_pkg::CMD_DESEL) [*4])
        else $error("command too soon after sleep exit");
    a_cke_hold: assert property ($changed(dram_cke) |=> $stable(dram_cke) [*2])
        else $error("clock-enable level shorter than minimum");
    a_sleep_max: assert property (res_count <= res_max)
        else $error("sleep residency past its limit");
    a_pre_gap: assert property ((dram_cmd inside {sdpd_pkg::CMD_PRE, sdpd_pkg::CMD_PREA,
        sdpd_pkg::CMD_REF}) && speed_hi |-> dram_cke [*2])
        else $error("precharge or refresh too close to sleep entry");
    a_read_gap: assert property (dram_cmd == sdpd_pkg::CMD_RD |-> dram_cke [*5])
        else $error("read too close to sleep entry");
    a_write_gap: assert property (dram_cmd == sdpd_pkg::CMD_WR && !chop |-> dram_cke [*4])
        else $error("write too close to sleep entry");
    a_wra_gap: assert property (dram_cmd == sdpd_pkg::CMD_WRA && !chop |-> dram_cke [*5])
        else $error("autoclose write too close to sleep entry");
    a_rfc_block: assert property (dram_cmd == sdpd_pkg::CMD_REF |-> !blk_if.zero
        || rfc_gap == GW'(1))
        else $error("refresh cycle time not enforced");
    a_cal_floor: assert property (timing[sdpd_pkg::TIM_CAL_LSB +: 4] >= 4'(sdpd_pkg::CAL_CYC))
        else $error("select latency below its floor");
    a_sleep_desel: assert property (!dram_cke |-> dram_cmd == sdpd_pkg::CMD_DESEL)
        else $error("command issued during sleep");
    a_entry_gap: assert property ($fell(dram_cke) |-> cmd_age >= cmd_need)
        else $error("sleep entry before the last command gap");
    a_exit_par: assert property (dram_cmd != sdpd_pkg::CMD_DESEL |-> wake_age >= wake_need)
        else $error("command before the exit delay elapsed");
endmodule

// [dv/sdpd_dram_model.sv]
// sdpd_dram_model: behavioural dram seen from its command and clock-enable pins
// assumes pins are sampled on the rising edge of hclk, which is the dram clock
`timescale 1ns/1ps
module sdpd_dram_model (
    input  wire logic       hclk,
    input  wire logic       hresetn,
    input  wire logic       dram_cke,
    input  wire logic [3:0] dram_cmd,
    input  wire logic [5:0] wl,
    input  wire logic       bc4_fixed,
    input  wire logic [4:0] xp,
    output int              bad_cmds,
    output int              wr_starts
);
    logic prev_cke;
    logic passed;
    int   pass_left;
    int   wake_left;
    int   cyc;
    int   wr_due[$];
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            prev_cke = 1'b1;
            pass_left = 0;
            wake_left = 0;
            cyc = 0;
            bad_cmds = 0;
            wr_starts = 0;
            wr_due.delete();
        end else begin
            cyc = cyc + 1;
            if (prev_cke && !dram_cke) pass_left = sdpd_pkg::CPDED_CYC;
            if (!prev_cke && dram_cke) wake_left = int'(xp) + 1;
            passed = dram_cke || (pass_left > 0);
            if (dram_cmd != 4'h0 && (!dram_cke || wake_left > 0)) bad_cmds++;
            if (passed && (dram_cmd == 4'h8 || dram_cmd == 4'h9)) begin
                wr_due.push_back(cyc + int'(wl) + (bc4_fixed ? 2 : 4));
            end
            if (wr_due.size() > 0 && wr_due[0] == cyc) begin
                void'(wr_due.pop_front());
                wr_starts++;
            end
            if (pass_left > 0) pass_left--;
            if (wake_left > 0) wake_left--;
            prev_cke = dram_cke;
        end
    end
endmodule

// [dv/sdpd_ctrl_tb.sv]
// sdpd_ctrl_tb: self-checking bench of the power-down timing controller
// assumes an ahb-lite master in this bench and the dram model on the pins
`timescale 1ns/1ps
module sdpd_ctrl_tb;
    typedef struct packed {
        logic [31:0] ctrl;
        logic [31:0] timing;
        logic [3:0]  code;
        logic [7:0]  gap;
    } sdpd_row_type;
    localparam logic [31:0] T0 = 32'h300E_180F;
    localparam logic [31:0] T1 = 32'h300E_181A;
    localparam sdpd_row_type ROWS [0:15] = '{
        '{32'h0000_090B, T0, 4'h1, 8'h01}, '{32'h0000_090B, T0, 4'h2, 8'h01},
        '{32'h0000_090B, T0, 4'h3, 8'h01}, '{32'h0000_090B, T0, 4'h4, 8'h0E},
        '{32'h0000_090B, T0, 4'h5, 8'h18}, '{32'h0000_090B, T0, 4'h6, 8'h10},
        '{32'h0000_090B, T0, 4'h7, 8'h10}, '{32'h0000_090B, T0, 4'h8, 8'h0E},
        '{32'h0000_090B, T0, 4'h9, 8'h0F}, '{32'h0400_090B, T0, 4'h2, 8'h02},
        '{32'h0400_090B, T0, 4'h3, 8'h02}, '{32'h0800_090B, T0, 4'h9, 8'h0D},
        '{32'h0800_090B, T0, 4'h8, 8'h0C}, '{32'h0000_090B, T1, 4'h8, 8'h0F},
        '{32'h0304_090B, T0, 4'h4, 8'h12}, '{32'h0104_090B, T0, 4'h4, 8'h0E}};
    logic        hclk;
    logic        hresetn;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic        dram_cke;
    logic [3:0]  dram_cmd;
    logic [31:0] cur_ctrl;
    logic [4:0]  cur_xp;
    logic [31:0] rd;
    logic        cke_q = 1'b1;
    int          cyc = 0;
    int          cmd_cyc = 0;
    int          fall_cyc = 0;
    int          rise_cyc = 0;
    int          bad_cmds;
    int          wr_starts;
    int          num_errors = 0;
    int          checks_done = 0;
    int          saved;

    sdpd_ctrl u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .dram_cke(dram_cke), .dram_cmd(dram_cmd));
    sdpd_dram_model u_dram (.hclk(hclk), .hresetn(hresetn), .dram_cke(dram_cke),
        .dram_cmd(dram_cmd), .wl(cur_ctrl[13:8]), .bc4_fixed(cur_ctrl[27]),
        .xp(cur_xp), .bad_cmds(bad_cmds), .wr_starts(wr_starts));

    initial begin
        hclk = 1'b0;
        forever #12.5 hclk = ~hclk;
    end

    always @(posedge hclk) begin
        cyc <= cyc + 1;
        cke_q <= dram_cke;
        if (dram_cmd !== 4'h0) cmd_cyc <= cyc;
        if (cke_q === 1'b1 && dram_cke === 1'b0) fall_cyc <= cyc;
        if (cke_q === 1'b0 && dram_cke === 1'b1) rise_cyc <= cyc;
    end

    task automatic final_report;
        $display("checks %0d, mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected word at %0t: got %08h, want %08h", $time, got, exp);
        end
    endtask

    task automatic check_span(input int got, input int lo, input int hi);
        checks_done++;
        if (got < lo || got > hi) begin
            num_errors++;
            $display("unexpected span at %0t: got %0h, want %0h..%0h", $time, got, lo, hi);
        end
    endtask

    task automatic ahb_xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                            output logic [31:0] q);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        ahb_xfer(1'b1, a, d, rd);
    endtask

    task automatic rd_reg(input logic [7:0] a, input logic [31:0] exp);
        ahb_xfer(1'b0, a, 32'h0000_0000, rd);
        check_word(rd, exp);
    endtask

    task automatic keep_writing(input logic [31:0] d, input logic [4:0] want);
        for (int i = 0; i < 80; i++) begin
            wr_reg(sdpd_pkg::CMD_OFF, d);
            @(negedge hclk);
            if ({dram_cke, dram_cmd} === want) break;
            @(posedge hclk);
        end
        repeat (2) @(posedge hclk);
    endtask

    task automatic do_reset;
        hresetn <= 1'b0;
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (2) @(posedge hclk);
    endtask

    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0000_0000;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0000_0000;
        cur_ctrl = sdpd_pkg::CTRL_RESET;
        cur_xp = 5'h04;
        do_reset();
        foreach (ROWS[i]) begin
            cur_ctrl = ROWS[i].ctrl;
            cur_xp = 5'(sdpd_pkg::XP_CYC + (cur_ctrl[24] ? int'(cur_ctrl[19:16]) : 0));
            wr_reg(sdpd_pkg::CTRL_OFF, ROWS[i].ctrl);
            wr_reg(sdpd_pkg::TIMING_OFF, ROWS[i].timing);
            wr_reg(sdpd_pkg::CMD_OFF, {28'h0, ROWS[i].code});
            keep_writing(32'h0000_0100, 5'h00);
            check_span(fall_cyc - cmd_cyc, ROWS[i].gap, ROWS[i].gap + 2);
            keep_writing(32'h0000_0200, 5'h10);
            saved = int'(cur_ctrl[13:8]) + 2;
            check_span(rise_cyc - fall_cyc, saved, saved + 2);
            keep_writing(32'h0000_0001, 5'h11);
            check_span(cmd_cyc - rise_cyc, cur_xp + 1, cur_xp + 3);
            $display("test row %0d done", i);
        end
        repeat (30) @(posedge hclk);
        check_span(bad_cmds, 0, 0);
        check_span(wr_starts, 5, 5);
        $display("test pin model done");
        cur_ctrl = sdpd_pkg::CTRL_RESET;
        cur_xp = 5'h04;
        do_reset();
        check_word({31'h0, dram_cke}, 32'h0000_0001);
        check_word({31'h0, hresp}, 32'h0000_0000);
        rd_reg(sdpd_pkg::CTRL_OFF, sdpd_pkg::CTRL_RESET);
        rd_reg(sdpd_pkg::TIMING_OFF, sdpd_pkg::TIMING_RESET);
        rd_reg(sdpd_pkg::STATUS_OFF, 32'h0000_0001);
        rd_reg(sdpd_pkg::CMD_OFF, 32'h0000_0000);
        rd_reg(8'h10, 32'h0000_0000);
        wr_reg(8'h10, 32'hFFFF_FFFF);
        rd_reg(8'h10, 32'h0000_0000);
        wr_reg(sdpd_pkg::TIMING_OFF, 32'h200E_180F);
        rd_reg(sdpd_pkg::TIMING_OFF, sdpd_pkg::TIMING_RESET);
        $display("test reset and registers done");
        keep_writing(32'h0000_0100, 5'h00);
        saved = cmd_cyc;
        wr_reg(sdpd_pkg::CMD_OFF, 32'h0000_0001);
        repeat (3) @(posedge hclk);
        check_span(cmd_cyc, saved, saved);
        rd_reg(sdpd_pkg::STATUS_OFF, 32'h0000_001A);
        wr_reg(sdpd_pkg::STATUS_OFF, 32'h0000_0008);
        rd_reg(sdpd_pkg::STATUS_OFF, 32'h0000_0012);
        $display("test refused in sleep done");
        for (int i = 0; i < 3000 && dram_cke !== 1'b1; i++) @(posedge hclk);
        repeat (2) @(posedge hclk);
        check_span(rise_cyc - fall_cyc, sdpd_pkg::RES_MAX_CYC, sdpd_pkg::RES_MAX_CYC + 8);
        $display("test forced exit done");
        final_report();
    end

    initial begin
        repeat (12000) @(posedge hclk);
        num_errors++;
        $display("unexpected timeout at %0t: got %08h, want %08h", $time, 32'h0, 32'h1);
        final_report();
    end
endmodule
